// ===== logic/qdl_link_if.sv
// Purpose: carries the assembled serial word from the link side to the core
// Assumes: the word only changes while a frame is open
// Notes: none
`timescale 1ns/1ps
`default_nettype none
`include "qdl_params.svh"

// ==========================================================
// link carrier
interface qdl_link_if;
   logic [`QDL_WORD_W-1:0] frame_word;
   modport rx (output frame_word);
   modport core (input frame_word);
endinterface

`default_nettype wire

// ===== logic/qdl_params.svh
// Purpose: named constants of the quad converter serial load block
// Assumes: included by every design file of the block by its bare name
// Notes: widths, field positions, reset values and pin order of the synchroniser
`ifndef QDL_PARAMS_SVH
`define QDL_PARAMS_SVH

// ==========================================================
// frame layout
`define QDL_WORD_W 24
`define QDL_DATA_W 14
`define QDL_PKG_W 5
`define QDL_CH_W 2
`define QDL_NUM_CH 4
`define QDL_PKG_HI 23
`define QDL_PKG_LO 19
`define QDL_CH_HI 15
`define QDL_CH_LO 14
`define QDL_DATA_HI 13
`define QDL_DATA_LO 0

// ==========================================================
// reset values
`define QDL_CODE_RST 14'h0000
`define QDL_PKG_RST 5'h00

// ==========================================================
// pin synchroniser: bit order and idle levels
`define QDL_SYNC_N 9
`define QDL_SYNC_FS 0
`define QDL_SYNC_LOAD 1
`define QDL_SYNC_CLR 2
`define QDL_SYNC_PKG_LO 3
`define QDL_SYNC_PKG_HI 7
`define QDL_SYNC_PAE 8
`define QDL_SYNC_RST 9'h007

`endif

// ===== logic/qdl_pkg.sv
// Purpose: shared types of the quad converter serial load block
// Assumes: qdl_params.svh holds the widths
// Notes: none
`default_nettype none
`include "qdl_params.svh"

// ==========================================================
// types
package qdl_pkg;
   typedef logic [`QDL_WORD_W-1:0] qdl_word_t;
   typedef logic [`QDL_DATA_W-1:0] qdl_code_t;
   typedef logic [`QDL_CH_W-1:0] qdl_chan_t;
   typedef logic [`QDL_PKG_W-1:0] qdl_pkg_addr_t;
   typedef qdl_code_t [`QDL_NUM_CH-1:0] qdl_bank_t;
   typedef enum logic {
      QDL_OUT_LIVE = 1'b0,
      QDL_OUT_GROUND = 1'b1
   } qdl_out_e;
endpackage

`default_nettype wire

// ===== logic/qdl_serial_rx.sv
// Purpose: serial shift register on the link clock
// Assumes: the host changes data and frame sync away from the falling clock edge
// Notes: no reset; the word is read only after a complete frame
`timescale 1ns/1ps
`default_nettype none
`include "qdl_params.svh"

module qdl_serial_rx
   import qdl_pkg::*;
(
   input wire logic link_sclk,
   input wire logic serial_data_in,
   input wire logic frame_sync_n,
   qdl_link_if.rx link
);

   qdl_word_t shift_reg;

   // ==========================================================
   // shift on the falling edge, only inside the frame
   always_ff @(negedge link_sclk) begin
      if (!frame_sync_n) begin
         shift_reg <= {shift_reg[`QDL_WORD_W-2:0], serial_data_in};
      end
   end

   // word is static while the frame is closed, so the core may read it
   assign link.frame_word = shift_reg;

   // ==========================================================
   // assertions
   property p_shift_in;
      @(negedge link_sclk) !frame_sync_n |=> shift_reg[0] == $past(serial_data_in);
   endproperty
   a_shift_in: assert property (p_shift_in) else $error("serial bit not shifted in");

   property p_idle_hold;
      @(negedge link_sclk) frame_sync_n |=> $stable(shift_reg);
   endproperty
   a_idle_hold: assert property (p_idle_hold) else $error("shift outside frame");

endmodule

`default_nettype wire

// ===== logic/qdl_top.sv
// Purpose: serial load, address decode and latch update of a quad converter
// Assumes: sys_clk at 200 MHz; link clock unrelated; pins asynchronous
// Notes: analogue stage is outside; sense_ground_level_sel steers it
//
// The placing of the registers and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "qdl_params.svh"

module qdl_top
   import qdl_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic link_sclk,
   input wire logic serial_data_in,
   input wire logic frame_sync_n,
   input wire logic [`QDL_PKG_W-1:0] package_address_pins,
   input wire logic package_address_enable,
   input wire logic load_latch_n,
   input wire logic output_clear_n,
   output logic [`QDL_NUM_CH-1:0][`QDL_DATA_W-1:0] dac_code,
   output logic [`QDL_NUM_CH-1:0][`QDL_DATA_W-1:0] input_code,
   output logic sense_ground_level_sel,
   output logic frame_accept,
   output logic frame_discard
);

   // ==========================================================
   // link side
   qdl_link_if link_bus();

   qdl_serial_rx u_rx (
      .link_sclk(link_sclk),
      .serial_data_in(serial_data_in),
      .frame_sync_n(frame_sync_n),
      .link(link_bus.rx)
   );

   // ==========================================================
   // pin synchronisers
   // three stages; a level is taken only when stages two and three agree
   logic [`QDL_SYNC_N-1:0] pin_raw;
   logic [`QDL_SYNC_N-1:0] pin_filt;
   logic [`QDL_SYNC_N-1:0] sync_rst_val;

   assign sync_rst_val = `QDL_SYNC_RST;
   assign pin_raw[`QDL_SYNC_FS] = frame_sync_n;
   assign pin_raw[`QDL_SYNC_LOAD] = load_latch_n;
   assign pin_raw[`QDL_SYNC_CLR] = output_clear_n;
   assign pin_raw[`QDL_SYNC_PKG_HI:`QDL_SYNC_PKG_LO] = package_address_pins;
   assign pin_raw[`QDL_SYNC_PAE] = package_address_enable;

   genvar g;
   generate
      for (g = 0; g < `QDL_SYNC_N; g = g + 1) begin : g_sync
         logic s1_reg;
         logic s2_reg;
         logic s3_reg;
         logic filt_reg;
         always_ff @(posedge sys_clk) begin
            if (rst) begin
               s1_reg <= sync_rst_val[g];
               s2_reg <= sync_rst_val[g];
               s3_reg <= sync_rst_val[g];
               filt_reg <= sync_rst_val[g];
            end else begin
               s1_reg <= pin_raw[g];
               s2_reg <= s1_reg;
               s3_reg <= s2_reg;
               if (s2_reg == s3_reg) begin
                  filt_reg <= s3_reg;
               end
            end
         end
         assign pin_filt[g] = filt_reg;
      end
   endgenerate

   logic fs_f;
   logic load_f;
   logic clr_f;
   logic pae_f;
   qdl_pkg_addr_t pkg_pins_f;

   assign fs_f = pin_filt[`QDL_SYNC_FS];
   assign load_f = pin_filt[`QDL_SYNC_LOAD];
   assign clr_f = pin_filt[`QDL_SYNC_CLR];
   assign pae_f = pin_filt[`QDL_SYNC_PAE];
   assign pkg_pins_f = pin_filt[`QDL_SYNC_PKG_HI:`QDL_SYNC_PKG_LO];

   // ==========================================================
   // frame end detection
   logic fs_prev_reg;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         // same idle level as the filtered pin, so no false frame end after reset
         fs_prev_reg <= sync_rst_val[`QDL_SYNC_FS];
      end else begin
         fs_prev_reg <= fs_f;
      end
   end

   logic frame_rise;
   assign frame_rise = fs_f & ~fs_prev_reg;

   // ==========================================================
   // frame decode
   // the word is read only after the frame closed, when the link side holds it still
   qdl_word_t word;
   qdl_pkg_addr_t pkg_field;
   qdl_chan_t ch_field;
   qdl_code_t data_field;
   logic pkg_match;
   logic accept;
   logic discard;

   assign word = link_bus.frame_word;
   assign pkg_field = word[`QDL_PKG_HI:`QDL_PKG_LO];
   assign ch_field = word[`QDL_CH_HI:`QDL_CH_LO];
   assign data_field = word[`QDL_DATA_HI:`QDL_DATA_LO];
   assign pkg_match = (pkg_field == pkg_pins_f);
   assign accept = frame_rise & (pae_f | pkg_match);
   assign discard = frame_rise & ~accept;

   // ==========================================================
   // input registers
   qdl_bank_t input_bank_reg;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         for (int i = 0; i < `QDL_NUM_CH; i++) begin
            input_bank_reg[i] <= `QDL_CODE_RST;
         end
      end else if (accept) begin
         input_bank_reg[ch_field] <= data_field;
      end
   end

   // ==========================================================
   // frame status pulses
   logic frame_accept_reg;
   logic frame_discard_reg;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         frame_accept_reg <= 1'b0;
         frame_discard_reg <= 1'b0;
      end else begin
         frame_accept_reg <= accept;
         frame_discard_reg <= discard;
      end
   end

   // ==========================================================
   // converter latches
   // transparent while load is low, so frames arriving then go straight through
   qdl_bank_t latch_bank_reg;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         for (int i = 0; i < `QDL_NUM_CH; i++) begin
            latch_bank_reg[i] <= `QDL_CODE_RST;
         end
      end else if (!load_f) begin
         latch_bank_reg <= input_bank_reg;
      end
   end

   // ==========================================================
   // output ground select
   // clear sets this flop without the clock; release and load use filtered copies,
   // so the asynchronous release of clear never decides the next state alone
   qdl_out_e out_state_reg;

   always_ff @(posedge sys_clk or negedge output_clear_n) begin
      if (!output_clear_n) begin
         out_state_reg <= QDL_OUT_GROUND;
      end else if (rst) begin
         out_state_reg <= QDL_OUT_GROUND;
      end else begin
         case (out_state_reg)
            QDL_OUT_GROUND: begin
               if (clr_f && !load_f) begin
                  out_state_reg <= QDL_OUT_LIVE;
               end
            end
            QDL_OUT_LIVE: begin
               if (!clr_f) begin
                  out_state_reg <= QDL_OUT_GROUND;
               end
            end
            default: begin
               out_state_reg <= QDL_OUT_GROUND;
            end
         endcase
      end
   end

   // ==========================================================
   // outputs
   assign dac_code = latch_bank_reg;
   assign input_code = input_bank_reg;
   assign sense_ground_level_sel = (out_state_reg == QDL_OUT_GROUND);
   assign frame_accept = frame_accept_reg;
   assign frame_discard = frame_discard_reg;

   // ==========================================================
   // assertion helpers
   qdl_bank_t prev_bank_reg;
   logic [`QDL_NUM_CH-1:0] bank_changed;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         for (int i = 0; i < `QDL_NUM_CH; i++) begin
            prev_bank_reg[i] <= `QDL_CODE_RST;
         end
      end else begin
         prev_bank_reg <= input_bank_reg;
      end
   end

   always_comb begin
      for (int i = 0; i < `QDL_NUM_CH; i++) begin
         bank_changed[i] = (input_bank_reg[i] != prev_bank_reg[i]);
      end
   end

   // ==========================================================
   // assertions
   default clocking cb_sys @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   sequence s_frame_end;
      !fs_f ##1 fs_f;
   endsequence

   sequence s_clear_released;
      !clr_f ##1 clr_f;
   endsequence

   sequence s_clear_held;
      !clr_f [*2];
   endsequence

   sequence s_frame_taken;
      frame_rise ##1 frame_accept_reg;
   endsequence

   property p_pkg_match;
      (frame_rise && !pae_f && pkg_match)
         |=> frame_accept_reg && input_bank_reg[$past(ch_field)] == $past(data_field);
   endproperty
   a_pkg_match: assert property (p_pkg_match) else $error("matching frame not stored");

   property p_broadcast;
      (frame_rise && pae_f)
         |=> frame_accept_reg && input_bank_reg[$past(ch_field)] == $past(data_field);
   endproperty
   a_broadcast: assert property (p_broadcast) else $error("broadcast frame not stored");

   property p_frame_end;
      s_frame_end |=> (frame_accept_reg || frame_discard_reg);
   endproperty
   a_frame_end: assert property (p_frame_end) else $error("frame end not handled");

   property p_latch_hold;
      load_f |=> $stable(latch_bank_reg);
   endproperty
   a_latch_hold: assert property (p_latch_hold) else $error("latch changed with load high");

   property p_latch_copy;
      !load_f |=> latch_bank_reg == $past(input_bank_reg);
   endproperty
   a_latch_copy: assert property (p_latch_copy) else $error("latches not copied together");

   property p_clear_async;
      !output_clear_n |-> sense_ground_level_sel;
   endproperty
   a_clear_async: assert property (p_clear_async) else $error("clear did not ground outputs");

   property p_clear_stay;
      s_clear_released ##0 load_f ##1 load_f |-> sense_ground_level_sel;
   endproperty
   a_clear_stay: assert property (p_clear_stay) else $error("outputs left ground early");

   property p_clear_return;
      (sense_ground_level_sel && clr_f && !load_f)
         |=> (!sense_ground_level_sel || !output_clear_n);
   endproperty
   a_clear_return: assert property (p_clear_return) else $error("outputs not returned");

   property p_clear_ignores_load;
      s_clear_held |-> sense_ground_level_sel;
   endproperty
   a_clear_ignores_load: assert property (p_clear_ignores_load) else $error("load not ignored");

   property p_discard;
      (frame_rise && !pae_f && !pkg_match)
         |=> frame_discard_reg && !frame_accept_reg && $stable(input_bank_reg);
   endproperty
   a_discard: assert property (p_discard) else $error("foreign frame changed registers");

   property p_one_channel;
      frame_accept_reg |-> $onehot0(bank_changed) && !frame_discard_reg;
   endproperty
   a_one_channel: assert property (p_one_channel) else $error("more than one channel written");

   property p_no_stray_write;
      !frame_accept_reg |-> bank_changed == '0;
   endproperty
   a_no_stray_write: assert property (p_no_stray_write) else $error("input register changed alone");

   property p_accept_pulse;
      s_frame_taken |=> !frame_accept_reg && !frame_discard_reg;
   endproperty
   a_accept_pulse: assert property (p_accept_pulse) else $error("frame pulse too long");

   // ground select may only leave through a low load level
   property p_ground_hold;
      (sense_ground_level_sel && load_f) |=> sense_ground_level_sel;
   endproperty
   a_ground_hold: assert property (p_ground_hold) else $error("ground left with load high");

   property p_discard_no_write;
      frame_discard_reg |-> bank_changed == '0;
   endproperty
   a_discard_no_write: assert property (p_discard_no_write) else $error("dropped frame stored");

endmodule

`default_nettype wire

// ===== test/qdl_host_model.sv
// Purpose: host side of the serial link, drives data, serial clock and frame sync
// Assumes: serial clock period 15 ns, unrelated in phase to the system clock
// Notes: serial clock stands high between frames; data is moved while the clock is high, 3.75 ns before each falling edge inside the frame
`timescale 1ns/1ps
`default_nettype none

module qdl_host_model (
   output logic link_sclk,
   output logic serial_data_in,
   output logic frame_sync_n
);
   // ==========================================================
   // idle levels
   initial begin
      link_sclk = 1'b1;
      serial_data_in = 1'b0;
      frame_sync_n = 1'b1;
   end

   // ==========================================================
   // one frame, msb first
   task automatic send(input logic [23:0] word);
      #2.3;
      frame_sync_n = 1'b0;
      #4;
      for (int i = 23; i >= 0; i--) begin
         serial_data_in = word[i];
         #3.75 link_sclk = 1'b0;
         #7.5 link_sclk = 1'b1;
         #3.75;
      end
      frame_sync_n = 1'b1;
      // a released data line must not keep looking valid
      serial_data_in = ~serial_data_in;
      // one stray clock pulse outside the frame must not shift anything
      #5 link_sclk = 1'b0;
      #7.5 link_sclk = 1'b1;
      #60;
   endtask
endmodule

`default_nettype wire

// ===== test/tb_top.sv
// Purpose: self-checking bench of the quad converter serial load block
// Assumes: host model drives the serial link; package address pins held static, address enable raised only for the broadcast case
// Notes: expectations come from the frame layout, never from the outputs
`timescale 1ns/1ps
`default_nettype none
`include "qdl_params.svh"

module tb_top import qdl_pkg::*; ;
   logic sys_clk, rst, pae, load_n, clr_n, sclk, din, fs_n, gsel, acc, disc;
   logic [`QDL_PKG_W-1:0] pins;
   logic [`QDL_NUM_CH-1:0][`QDL_DATA_W-1:0] dac_code, input_code;
   qdl_bank_t exp_in;
   int errors, n_checks, n_acc, n_disc;
   localparam qdl_pkg_addr_t MY_PKG = 5'h15;

   always #2.5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      if (acc === 1'b1) n_acc++;
      if (disc === 1'b1) n_disc++;
   end

   qdl_host_model u_qdl_host_model (.link_sclk(sclk), .serial_data_in(din), .frame_sync_n(fs_n));
   qdl_top u_qdl_top (.sys_clk(sys_clk), .rst(rst), .link_sclk(sclk), .serial_data_in(din),
      .frame_sync_n(fs_n), .package_address_pins(pins), .package_address_enable(pae),
      .load_latch_n(load_n), .output_clear_n(clr_n), .dac_code(dac_code),
      .input_code(input_code), .sense_ground_level_sel(gsel), .frame_accept(acc),
      .frame_discard(disc));

   // ==========================================================
   // shared tasks
   task automatic check(input logic [55:0] seen, input logic [55:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wrap_up;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   // bits 18:16 carry a non-zero filler that must be ignored
   task automatic frame(input logic [4:0] pkg, input logic [1:0] ch, input logic [13:0] d,
                        input logic take);
      int a0, d0;
      a0 = n_acc;
      d0 = n_disc;
      u_qdl_host_model.send({pkg, 3'h5, ch, d});
      repeat (20) @(posedge sys_clk);
      check(56'(n_acc - a0), 56'(take));
      check(56'(n_disc - d0), 56'(!take));
      if (take) exp_in[ch] = d;
      check(input_code, exp_in);
   endtask

   task automatic settle(input logic want_sel);
      for (int i = 0; i < 12; i++) begin
         @(posedge sys_clk);
         #1;
         if (gsel === want_sel && dac_code === exp_in) break;
      end
   endtask

   // ==========================================================
   // scenarios
   task automatic t_reset;
      check(dac_code, 56'h0);
      check(input_code, 56'h0);
      check(56'(gsel), 56'h1);
      check(56'({acc, disc}), 56'h0);
   endtask

   task automatic t_address;
      logic [13:0] tbl [4] = '{14'h3FFF, 14'h0001, 14'h2AAA, 14'h1555};
      for (int c = 0; c < 4; c++) frame(MY_PKG, 2'(c), tbl[c], 1'b1);
      frame(MY_PKG ^ 5'h01, 2'h2, 14'h0F0F, 1'b0);
      frame(MY_PKG ^ 5'h10, 2'h0, 14'h0000, 1'b0);
      repeat (10) @(posedge sys_clk);
      check(dac_code, 56'h0);
   endtask

   task automatic t_broadcast;
      @(posedge sys_clk);
      pae <= 1'b1;
      repeat (6) @(posedge sys_clk);
      frame(5'h0A, 2'h1, 14'h0123, 1'b1);
      @(posedge sys_clk);
      pae <= 1'b0;
      check(dac_code, 56'h0);
   endtask

   task automatic t_load;
      @(posedge sys_clk);
      load_n <= 1'b0;
      settle(1'b0);
      check(dac_code, exp_in);
      check(56'(gsel), 56'h0);
   endtask

   task automatic t_clear;
      @(posedge sys_clk);
      clr_n <= 1'b0;
      #1 check(56'(gsel), 56'h1);
      for (int i = 0; i < 8; i++) begin
         @(posedge sys_clk);
         #1 check(56'(gsel), 56'h1);
      end
      @(posedge sys_clk);
      clr_n <= 1'b1;
      load_n <= 1'b1;
      repeat (12) @(posedge sys_clk);
      #1 check(56'(gsel), 56'h1);
      @(posedge sys_clk);
      load_n <= 1'b0;
      settle(1'b0);
      check(56'(gsel), 56'h0);
      check(dac_code, exp_in);
   endtask

   // ==========================================================
   // main sequence and watchdog
   initial begin
      sys_clk = 1'b0;
      rst = 1'b1;
      pae = 1'b0;
      load_n = 1'b1;
      clr_n = 1'b1;
      pins = MY_PKG;
      exp_in = '0;
      repeat (4) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      #1;
      t_reset();
      t_address();
      t_broadcast();
      t_load();
      t_clear();
      wrap_up();
   end

   // whole run is a few microseconds, so this only trips on a hang
   initial begin
      #100000;
      errors++;
      wrap_up();
   end
endmodule

`default_nettype wire
